// File: logic/bbr_pkg.sv
// package for the buck-boost regulator control block: register map,
// field positions, reset values, mode codes and timing counts.
// assumes a 50 MHz system clock and a 32-bit avalon-mm register bus.
package bbr_pkg;
  // register byte offsets
  localparam logic [5:0] BBR_OFS_CTRL = 6'h00;
  localparam logic [5:0] BBR_OFS_STATUS = 6'h04;
  localparam logic [5:0] BBR_OFS_MASK = 6'h08;
  localparam logic [5:0] BBR_OFS_STATE = 6'h0c;
  // hardware_control_word field positions
  localparam int BBR_CTL_BOOST_EN = 0;
  localparam int BBR_CTL_BOOST_SEL = 1;
  localparam int BBR_CTL_BOOST_HIGH = 2;
  localparam int BBR_CTL_PWM_AUTO = 3;
  localparam int BBR_CTL_PWM_BY_WAKE = 4;
  localparam logic [4:0] BBR_CTL_RESET = 5'h08;
  // converter_status_flags field positions
  localparam int BBR_ST_BUCK_OPEN = 0;
  localparam int BBR_ST_BUCK_SHORT = 1;
  localparam int BBR_ST_BUCK_WINDOW = 2;
  localparam int BBR_ST_BOOST_OPEN = 3;
  localparam int BBR_ST_BOOST_SHORT = 4;
  localparam int BBR_ST_GND_LOSS = 5;
  localparam int BBR_ST_BOOST_ACT = 6;
  localparam int BBR_ST_AUTO_PWM = 7;
  localparam logic [7:0] BBR_STATUS_RESET = 8'h00;
  localparam logic [7:0] BBR_MASK_RESET = 8'h00;
  // operating mode codes presented by the mode controller
  localparam logic [2:0] BBR_MODE_NORMAL = 3'h0;
  localparam logic [2:0] BBR_MODE_SLEEP = 3'h1;
  localparam logic [2:0] BBR_MODE_STOP = 3'h2;
  localparam logic [2:0] BBR_MODE_RESTART = 3'h3;
  localparam logic [2:0] BBR_MODE_FAILSAFE = 3'h4;
  // boost level codes driven to the power stage
  localparam logic [1:0] BBR_LVL_LOW = 2'h1;
  localparam logic [1:0] BBR_LVL_MID = 2'h2;
  localparam logic [1:0] BBR_LVL_TOP = 2'h3;
  // supply thresholds in sensed-level codes
  localparam logic [9:0] BBR_TH1 = 10'h180;
  localparam logic [9:0] BBR_HYS1 = 10'h020;
  localparam logic [9:0] BBR_TH2 = 10'h1c0;
  localparam logic [9:0] BBR_HYS2 = 10'h020;
  // buck target and 12 percent window
  localparam logic [9:0] BBR_BUCK_TARGET = 10'h200;
  localparam int BBR_WINDOW_PCT = 12;
  localparam logic [9:0] BBR_BUCK_WIN = 10'((int'(BBR_BUCK_TARGET) * BBR_WINDOW_PCT) / 100);
  // duty cycle codes
  localparam logic [7:0] BBR_DUTY_MIN = 8'h08;
  localparam logic [7:0] BBR_DUTY_STEP = 8'h08;
  localparam logic [7:0] BBR_DUTY_FULL = 8'hff;
  localparam logic [7:0] BBR_SS_HOLD = 8'h08;
  // switching period timing
  localparam int BBR_CLK_PERIOD_NS = 20;
  localparam int BBR_SW_PERIOD_NS = 500;
  localparam logic [7:0] BBR_SW_PERIOD_CYC = 8'(BBR_SW_PERIOD_NS / BBR_CLK_PERIOD_NS);
  // soft start states
  typedef enum logic [2:0] {
    BBR_SS_OFF = 3'b001,
    BBR_SS_RAMP = 3'b010,
    BBR_SS_REG = 3'b100
  } bbr_ss_t;
endpackage : bbr_pkg

// File: logic/bbr_ctrl.sv
// buck-boost regulator control: cascade enable, buck modulation choice,
// buck soft start and regulation loop, boost level and hysteresis,
// sticky status flags with mask and interrupt, avalon-mm register slave.
// assumes all inputs synchronous to clk_sys_in and levels from comparators.
`timescale 1ns/1ps
`default_nettype none
module bbr_ctrl
  import bbr_pkg::*;
(
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic reset_in,
  // avalon-mm slave
  input wire logic [5:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // operating mode and sensing
  input wire logic [2:0] sbc_mode_in,
  input wire logic [9:0] sensed_supply_level_in,
  input wire logic [9:0] main_regulated_output_in,
  input wire logic load_above_pfm_limit_in,
  input wire logic wake_level_in,
  // fault comparators from the power stage
  input wire logic buck_switch_pin_open_in,
  input wire logic buck_switch_pin_short_in,
  input wire logic boost_pin_open_in,
  input wire logic boost_pin_short_in,
  input wire logic boost_gnd_loss_in,
  // power stage control
  output logic cascade_en_out,
  output logic buck_pwm_mode_out,
  output logic [7:0] buck_duty_out,
  output logic soft_start_busy_out,
  output logic boost_on_out,
  output logic [1:0] boost_level_out,
  // interrupt
  output logic irq_out
);

  // the state struct holds every flip-flop of the block,
  // so one always_ff registers it and reset is written
  // in one place; each output but the busy flag reads a field directly.
  // hazard: a field added here needs a value in the
  // reset aggregate, or it starts unknown.
  // groups: registers, mode tracking, soft start,
  // boost, bus answer, output copies.

  // whole block state
  typedef struct packed {
    logic [4:0] ctrl;       // hardware_control_word
    logic [7:0] status;     // converter_status_flags
    logic [7:0] mask;       // interrupt mask
    logic [2:0] prev_mode;  // mode seen last cycle
    logic stop_pwm;         // auto pfm to pwm latch in stop
    bbr_ss_t ss;            // soft start state
    logic [7:0] duty;       // buck duty code
    logic [7:0] hold_cnt;   // switching periods left at this step
    logic [7:0] per_cnt;    // clock cycles inside a switching period
    logic boost_on;         // boost switch running
    logic [1:0] level;      // boost level
    logic wait_n;           // low while answer stands on the bus
    logic [31:0] rdata;     // registered read data
    logic irq;              // interrupt output
    logic cascade_en;       // cascade enable output
    logic pwm_mode;         // buck modulation output
  } bbr_state_t;

  bbr_state_t cur;
  bbr_state_t next_cur;

  // the low level has its own threshold pair; the
  // middle and top levels share the second pair.
  // switch-on is strictly below the threshold and
  // switch-off strictly above threshold plus
  // hysteresis, so a supply inside the band keeps
  // the present state.

  // activation threshold for a level
  function automatic logic [9:0] bbr_thr(input logic [1:0] lvl);
    bbr_thr = (lvl == BBR_LVL_LOW) ? BBR_TH1 : BBR_TH2;
  endfunction : bbr_thr

  // switch-off level, threshold plus hysteresis
  function automatic logic [9:0] bbr_thr_off(input logic [1:0] lvl);
    bbr_thr_off = (lvl == BBR_LVL_LOW) ? (BBR_TH1 + BBR_HYS1) : (BBR_TH2 + BBR_HYS2);
  endfunction : bbr_thr_off

  // duty increase saturating at full scale
  function automatic logic [7:0] bbr_duty_add(input logic [7:0] d, input logic [7:0] inc);
    logic [8:0] sum;
    sum = {1'b0, d} + {1'b0, inc};
    bbr_duty_add = sum[8] ? BBR_DUTY_FULL : sum[7:0];
  endfunction : bbr_duty_add

  // helpers are plain wires filled inside the
  // next-state process; none holds state, and each
  // is assigned on every pass, so no latch forms.
  // bus_commit marks the edge at which a request is
  // honoured: a write lands, a status read clears.

  // combinational helpers
  logic mode_active;
  logic prev_active;
  logic stop_entry;
  logic boost_allowed;
  logic period_end;
  logic [1:0] sel_level;
  logic [9:0] win_err;
  logic out_of_window;
  logic bus_req;
  logic bus_commit;
  logic [7:0] st_set;
  logic [7:0] st_clr;
  logic [31:0] rd_val;

  // next-state logic
  always_comb begin
    next_cur = cur;
    // every field keeps its value unless a branch
    // below assigns it; each section overrides only
    // the fields that it owns.
    // cascade runs only in normal, stop and restart
    mode_active = (sbc_mode_in == BBR_MODE_NORMAL) || (sbc_mode_in == BBR_MODE_STOP) ||
                  (sbc_mode_in == BBR_MODE_RESTART);
    prev_active = (cur.prev_mode == BBR_MODE_NORMAL) || (cur.prev_mode == BBR_MODE_STOP) ||
                  (cur.prev_mode == BBR_MODE_RESTART);
    stop_entry = (sbc_mode_in == BBR_MODE_STOP) && (cur.prev_mode != BBR_MODE_STOP);
    // boost honoured in normal and stop, kept as configured in restart
    boost_allowed = mode_active && cur.ctrl[BBR_CTL_BOOST_EN];
    period_end = (cur.per_cnt == BBR_SW_PERIOD_CYC - 8'h01);
    // level from select and high bits
    if (cur.ctrl[BBR_CTL_BOOST_SEL]) begin
      sel_level = BBR_LVL_LOW;
    end else if (cur.ctrl[BBR_CTL_BOOST_HIGH]) begin
      sel_level = BBR_LVL_TOP;
    end else begin
      sel_level = BBR_LVL_MID;
    end
    // buck output window
    win_err = (main_regulated_output_in >= BBR_BUCK_TARGET) ?
              (main_regulated_output_in - BBR_BUCK_TARGET) : (BBR_BUCK_TARGET - main_regulated_output_in);
    out_of_window = mode_active && (cur.ss == BBR_SS_REG) && (win_err > BBR_BUCK_WIN);
    next_cur.prev_mode = sbc_mode_in;
    next_cur.cascade_en = mode_active;

    // a switching period is a fixed count of clocks;
    // the ramp hold and the closed loop advance only
    // at a period end, so the duty moves at most
    // once per switching period.
    // the counter is held at zero while the cascade
    // is off, so a fresh start sees full periods.
    // switching period counter, stopped while the cascade is off
    if (!mode_active || period_end) begin
      next_cur.per_cnt = 8'h00;
    end else begin
      next_cur.per_cnt = cur.per_cnt + 8'h01;
    end

    // soft start walks off, ramp, regulation.
    // off: duty zero; an inactive-to-active mode
    // change, power-up included, loads the minimum
    // duty and the hold count and enters the ramp.
    // ramp: duty held some switching periods, then
    // raised by one fixed step, until the sensed
    // buck output reaches its target.
    // regulation: one code up or down per period.
    // limitation: the loop watches only the output
    // code; supply and load act through that code.
    // soft start and regulation loop
    unique case (cur.ss)
      BBR_SS_OFF: begin
        next_cur.duty = 8'h00;
        // every off-to-on edge, power-up included, starts a soft start
        if (mode_active && !prev_active) begin
          next_cur.ss = BBR_SS_RAMP;
          next_cur.duty = BBR_DUTY_MIN;
          next_cur.hold_cnt = BBR_SS_HOLD;
        end
      end
      BBR_SS_RAMP: begin
        if (main_regulated_output_in >= BBR_BUCK_TARGET) begin
          next_cur.ss = BBR_SS_REG;
        end else if (period_end) begin
          if (cur.hold_cnt == 8'h01) begin
            // step up after holding this duty
            next_cur.duty = bbr_duty_add(cur.duty, BBR_DUTY_STEP);
            next_cur.hold_cnt = BBR_SS_HOLD;
          end else begin
            next_cur.hold_cnt = cur.hold_cnt - 8'h01;
          end
        end
      end
      BBR_SS_REG: begin
        // closed loop, one duty step per switching period
        if (period_end) begin
          if (main_regulated_output_in < BBR_BUCK_TARGET) begin
            // may climb to full duty on low input supply
            next_cur.duty = bbr_duty_add(cur.duty, 8'h01);
          end else if (main_regulated_output_in > BBR_BUCK_TARGET && cur.duty != 8'h00) begin
            next_cur.duty = cur.duty - 8'h01;
          end
        end
      end
      default: begin
        next_cur.ss = BBR_SS_OFF;
      end
    endcase
    // disabled cascade drops the loop at once
    if (!mode_active) begin
      next_cur.ss = BBR_SS_OFF;
      next_cur.duty = 8'h00;
    end

    // in stop the buck runs pfm by default; two ways
    // lead to pwm: the automatic latch on a heavy
    // load when enabled, and the wake pin when the
    // manual bit is set.
    // the latch clears on each fresh stop entry, so
    // a new stop returns to pfm first unless the manual bit is set and the wake pin is high.
    // outside stop the buck is pwm while it runs.
    // the latch event is reported once in status.
    // buck modulation choice
    st_set = 8'h00;
    if (stop_entry) begin
      next_cur.stop_pwm = 1'b0; // entry always clears the automatic latch
    end else if (sbc_mode_in == BBR_MODE_STOP && cur.ctrl[BBR_CTL_PWM_AUTO] &&
                 load_above_pfm_limit_in && !cur.stop_pwm) begin
      next_cur.stop_pwm = 1'b1;
      st_set[BBR_ST_AUTO_PWM] = 1'b1;
    end
    if (sbc_mode_in == BBR_MODE_STOP) begin
      // pfm unless an automatic or manual transition asks for pwm
      next_cur.pwm_mode = (!stop_entry && cur.stop_pwm) ||
                          (cur.ctrl[BBR_CTL_PWM_BY_WAKE] && wake_level_in);
    end else begin
      next_cur.pwm_mode = mode_active; // fixed-frequency pwm
    end

    // the level is copied from the select bits only
    // while the cascade runs, so sleep or fail-safe
    // cannot pick up settings written meanwhile.
    // the switch runs only while enabled and the mode
    // allows it; otherwise it is forced off at once.
    // activation sets the boost active flag, which a
    // status read may clear only above threshold.
    // boost level follows settings only while the cascade runs
    if (mode_active) begin
      next_cur.level = sel_level;
    end
    // boost hysteresis, always fixed-frequency pwm when running
    if (!boost_allowed) begin
      next_cur.boost_on = 1'b0;
    end else if (!cur.boost_on && sensed_supply_level_in < bbr_thr(cur.level)) begin
      next_cur.boost_on = 1'b1;
      st_set[BBR_ST_BOOST_ACT] = 1'b1;
    end else if (cur.boost_on && sensed_supply_level_in > bbr_thr_off(cur.level)) begin
      next_cur.boost_on = 1'b0;
    end

    // comparators only set flags; nothing on the mode
    // or configuration path reads the status word.
    // buck faults count while the cascade runs, boost
    // faults only while the boost switch runs, so an
    // idle stage cannot report a stale open pin.
    // the window check runs only during regulation.
    // fault flags, informational only
    st_set[BBR_ST_BUCK_OPEN] = mode_active && buck_switch_pin_open_in;
    st_set[BBR_ST_BUCK_SHORT] = mode_active && buck_switch_pin_short_in;
    st_set[BBR_ST_BUCK_WINDOW] = out_of_window;
    st_set[BBR_ST_BOOST_OPEN] = cur.boost_on && boost_pin_open_in;
    st_set[BBR_ST_BOOST_SHORT] = cur.boost_on && boost_pin_short_in;
    st_set[BBR_ST_GND_LOSS] = cur.boost_on && boost_gnd_loss_in;

    // a request seen with waitrequest high loads the
    // read word and drops waitrequest for one cycle;
    // at the next edge the request commits.
    // the read word comes from the state before the
    // commit, so the master sees exactly what a
    // status read is about to clear.
    // a master must hold its request until it samples
    // waitrequest low; dropping it early loses the
    // transfer without an error.
    // bus slave: answer one cycle after the request is seen
    bus_req = avs_read_in || avs_write_in;
    bus_commit = !cur.wait_n && bus_req;
    next_cur.wait_n = 1'b1;
    unique case (avs_address_in)
      BBR_OFS_CTRL: rd_val = {27'h0000000, cur.ctrl};
      BBR_OFS_STATUS: rd_val = {24'h000000, cur.status};
      BBR_OFS_MASK: rd_val = {24'h000000, cur.mask};
      BBR_OFS_STATE: rd_val = {12'h000, cur.duty, 1'b0, cur.ss, cur.level, cur.boost_on,
                               cur.pwm_mode, 1'b0, cur.prev_mode};
      default: rd_val = 32'h00000000;
    endcase
    if (cur.wait_n && bus_req) begin
      next_cur.wait_n = 1'b0;
      next_cur.rdata = avs_read_in ? rd_val : 32'h00000000;
    end

    // only bits in the answered word clear, so an
    // event between the load of the read word and
    // the commit is kept for the next read.
    // an event in the commit cycle itself wins over
    // the clear of the same bit.
    // the interrupt level is the masked next status.
    // read of status clears only bits that were reported
    st_clr = 8'h00;
    if (bus_commit && avs_read_in && avs_address_in == BBR_OFS_STATUS) begin
      st_clr = cur.rdata[7:0];
      // boost active flag stays while supply is below threshold
      if (sensed_supply_level_in <= bbr_thr(cur.level)) begin
        st_clr[BBR_ST_BOOST_ACT] = 1'b0;
      end
    end
    // set wins over clear
    next_cur.status = (cur.status & ~st_clr) | st_set;

    // register writes take effect at the committing edge
    if (bus_commit && avs_write_in) begin
      if (avs_address_in == BBR_OFS_CTRL) begin
        next_cur.ctrl = avs_writedata_in[4:0];
      end else if (avs_address_in == BBR_OFS_MASK) begin
        next_cur.mask = avs_writedata_in[7:0];
      end
    end
    next_cur.irq = |(next_cur.status & next_cur.mask);
  end

  // reset is synchronous and restores every field;
  // the previous mode resets to sleep, so the first
  // running mode after reset starts a soft start.
  // the answer flag resets high: no answer stands.

  // single state register
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      cur <= '{ctrl: BBR_CTL_RESET, status: BBR_STATUS_RESET, mask: BBR_MASK_RESET,
               prev_mode: BBR_MODE_SLEEP, stop_pwm: 1'b0, ss: BBR_SS_OFF, duty: 8'h00,
               hold_cnt: 8'h00, per_cnt: 8'h00, boost_on: 1'b0, level: BBR_LVL_MID,
               wait_n: 1'b1, rdata: 32'h00000000, irq: 1'b0, cascade_en: 1'b0,
               pwm_mode: 1'b0};
    end else begin
      cur <= next_cur;
    end
  end

  // every output reads a state field; the busy flag
  // reads the one-hot ramp code of the soft start
  // state, so it changes only at a clock edge.
  // no output depends on an input in the same cycle.
  // the level output holds its last value while off.
  // the duty output is zero whenever the cascade is off.

  // outputs straight from the state register
  assign avs_readdata_out = cur.rdata;
  assign avs_waitrequest_out = cur.wait_n;
  assign cascade_en_out = cur.cascade_en;
  assign buck_pwm_mode_out = cur.pwm_mode;
  assign buck_duty_out = cur.duty;
  assign soft_start_busy_out = (cur.ss == BBR_SS_RAMP);
  assign boost_on_out = cur.boost_on;
  assign boost_level_out = cur.level;
  assign irq_out = cur.irq;

endmodule : bbr_ctrl
`default_nettype wire

// File: sim/bbr_ctrl_checker.sv
// checker for bbr_ctrl: mode, modulation, soft start and boost relations
// assumes it is bound to bbr_ctrl, one clock domain
`timescale 1ns/1ps
`default_nettype none
module bbr_ctrl_checker
  import bbr_pkg::*;
(
  // clock, reset and stimulus
  input wire logic clk_sys_in,
  input wire logic reset_in,
  input wire logic [2:0] sbc_mode_in,
  input wire logic [9:0] sensed_supply_level_in,
  input wire logic [9:0] main_regulated_output_in,
  input wire logic load_above_pfm_limit_in,
  input wire logic wake_level_in,
  // watched outputs
  input wire logic cascade_en_out,
  input wire logic buck_pwm_mode_out,
  input wire logic [7:0] buck_duty_out,
  input wire logic soft_start_busy_out,
  input wire logic boost_on_out,
  input wire logic [1:0] boost_level_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (reset_in);
  // true for the modes that run the cascade
  function automatic logic act(input logic [2:0] m);
    return m == BBR_MODE_NORMAL || m == BBR_MODE_STOP || m == BBR_MODE_RESTART;
  endfunction : act
  // fresh stop entry with no pwm request pending
  sequence stop_entry;
    sbc_mode_in == BBR_MODE_STOP && $past(sbc_mode_in) != BBR_MODE_STOP && !wake_level_in && !load_above_pfm_limit_in;
  endsequence
  // step from an off mode into a running one
  sequence wake_entry;
    act(sbc_mode_in) && !act($past(sbc_mode_in));
  endsequence
  a_cascade_mode: assert property (!$past(reset_in) |-> cascade_en_out == act($past(sbc_mode_in)))
    else $error("cascade enable does not follow mode");
  a_off_quiet: assert property (!cascade_en_out |-> buck_duty_out == 8'h00 && !boost_on_out && !buck_pwm_mode_out)
    else $error("stage active while cascade off");
  a_off_boost: assert property (!act(sbc_mode_in) |=> !boost_on_out)
    else $error("boost on in off mode");
  a_stop_pfm: assert property (stop_entry |=> !buck_pwm_mode_out)
    else $error("stop entry kept pwm");
  a_run_pwm: assert property (!$past(reset_in) && sbc_mode_in != BBR_MODE_STOP && act(sbc_mode_in)
    && $past(sbc_mode_in) == sbc_mode_in |-> buck_pwm_mode_out)
    else $error("pwm missing in normal or restart");
  a_ss_begin: assert property (wake_entry |=> soft_start_busy_out && buck_duty_out == BBR_DUTY_MIN)
    else $error("soft start did not begin at minimum duty");
  a_ss_step: assert property (soft_start_busy_out && $past(soft_start_busy_out) |->
    buck_duty_out == $past(buck_duty_out) || buck_duty_out == 8'($past(buck_duty_out) + BBR_DUTY_STEP))
    else $error("soft start duty moved by a wrong step");
  a_ss_handover: assert property ($fell(soft_start_busy_out) && cascade_en_out |->
    $past(main_regulated_output_in) >= BBR_BUCK_TARGET)
    else $error("soft start ended below target");
  a_boost_rise: assert property ($rose(boost_on_out) |-> act($past(sbc_mode_in)) &&
    $past(sensed_supply_level_in) < (boost_level_out == BBR_LVL_LOW ? BBR_TH1 : BBR_TH2))
    else $error("boost started above threshold");
endmodule : bbr_ctrl_checker
`default_nettype wire

// File: sim/bbr_power_stage.sv
// power stage model: buck output code follows the duty code
// assumes duty 0x80 lands on the target output code
`timescale 1ns/1ps
`default_nettype none
module bbr_power_stage (
  // clock and stage controls
  input wire logic clk_sys_in,
  input wire logic cascade_en_in,
  input wire logic [7:0] duty_in,
  // sensed buck output
  output logic [9:0] out_level_out
);
  // output collapses when off, else four times duty one clock later
  always @(posedge clk_sys_in) begin
    out_level_out <= cascade_en_in ? {duty_in, 2'h0} : 10'h000;
  end
endmodule : bbr_power_stage
`default_nettype wire

// File: sim/buck_boost_regulator_control_bench.sv
// self-checking bench for bbr_ctrl with power stage model
// assumes bbr_pkg, bbr_ctrl, model and checker compiled first
`timescale 1ns/1ps
`default_nettype none
`define BBR_CHK(nm, e, s) begin n_compared++; if ((s) !== (e)) begin n_fail++; \
  $display("MISMATCH %s exp %h got %h", nm, e, s); end end
module buck_boost_regulator_control_bench import bbr_pkg::*;;
  logic clk_sys_in = 1'h0;
  logic reset_in = 1'h1;
  logic [5:0] avs_address_in = 6'h00;
  logic avs_read_in = 1'h0;
  logic avs_write_in = 1'h0;
  logic [31:0] avs_writedata_in = 32'h0;
  logic [31:0] avs_readdata_out, exp_w;
  logic [2:0] sbc_mode_in = BBR_MODE_NORMAL;
  logic [9:0] sensed_supply_level_in = 10'h3ff, main_regulated_output_in, v;
  logic load_above_pfm_limit_in = 1'h0;
  logic wake_level_in = 1'h0;
  logic [4:0] flt = 5'h00; // fault levels to the comparator inputs
  logic avs_waitrequest_out, cascade_en_out, buck_pwm_mode_out, soft_start_busy_out, boost_on_out, irq_out;
  logic [7:0] buck_duty_out;
  logic [1:0] boost_level_out;
  logic [31:0] exp_q[$]; // expected read words, oldest first
  logic bon = 1'h0; // modelled boost switch
  logic [2:0] offm[2] = '{BBR_MODE_SLEEP, BBR_MODE_FAILSAFE};
  int n_fail = 0;
  int n_compared = 0;
  always #10 clk_sys_in = ~clk_sys_in;
  bbr_ctrl i_bbr_ctrl (.clk_sys_in, .reset_in, .avs_address_in, .avs_read_in, .avs_write_in, .avs_writedata_in,
    .avs_readdata_out, .avs_waitrequest_out, .sbc_mode_in, .sensed_supply_level_in, .main_regulated_output_in,
    .load_above_pfm_limit_in, .wake_level_in, .buck_switch_pin_open_in(flt[0]), .buck_switch_pin_short_in(flt[1]),
    .boost_pin_open_in(flt[2]), .boost_pin_short_in(flt[3]), .boost_gnd_loss_in(flt[4]), .cascade_en_out,
    .buck_pwm_mode_out, .buck_duty_out, .soft_start_busy_out, .boost_on_out, .boost_level_out, .irq_out);
  bbr_power_stage i_bbr_power_stage (.clk_sys_in, .cascade_en_in(cascade_en_out), .duty_in(buck_duty_out),
    .out_level_out(main_regulated_output_in));
  // compares each read answer with the oldest note
  always @(posedge clk_sys_in) begin
    if (avs_read_in && avs_waitrequest_out === 1'h0) begin
      exp_w = exp_q.pop_front();
      `BBR_CHK("read data", exp_w, avs_readdata_out)
    end
  end
  // prints the verdict and ends the run
  task automatic report_and_stop();
    if (n_fail == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : report_and_stop
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_in);
  endtask : cyc
  // one bus cycle; for a read d is the expected word
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    int k;
    if (!wr) exp_q.push_back(d);
    @(posedge clk_sys_in);
    avs_address_in <= a;
    avs_write_in <= wr;
    avs_read_in <= !wr;
    avs_writedata_in <= wr ? d : 32'h0;
    k = 0;
    do begin @(posedge clk_sys_in); k++; end while (avs_waitrequest_out !== 1'h0 && k < 50);
    if (k >= 50) begin n_fail++; report_and_stop(); end
    avs_read_in <= 1'h0;
    avs_write_in <= 1'h0;
  endtask : bus
  task automatic mode_to(input logic [2:0] m);
    @(posedge clk_sys_in);
    sbc_mode_in <= m;
    cyc(3);
  endtask : mode_to
  // waits, bounded, for the soft start ramp to hand over
  task automatic settle();
    int k;
    k = 0;
    do begin @(posedge clk_sys_in); k++; end while (soft_start_busy_out !== 1'h0 && k < 8000);
    if (k >= 8000) begin n_fail++; report_and_stop(); end
    `BBR_CHK("regulating", 2'h3, {cascade_en_out, buck_pwm_mode_out})
  endtask : settle
  initial begin
    void'($urandom(32'hce05));
    cyc(10);
    reset_in <= 1'h0;
    // reset values and an unmapped place
    bus(1'h0, BBR_OFS_CTRL, {27'h0, BBR_CTL_RESET});
    bus(1'h0, BBR_OFS_MASK, 32'h0);
    bus(1'h1, 6'h20, 32'hffff_ffff);
    bus(1'h0, 6'h20, 32'h0);
    settle();
    bus(1'h0, BBR_OFS_STATUS, 32'h0);
    // every select and high combination
    for (int i = 0; i < 4; i++) begin
      bus(1'h1, BBR_OFS_CTRL, 32'(9 | (i << 1)));
      cyc(3);
      `BBR_CHK("level", i[0] ? BBR_LVL_LOW : (i[1] ? BBR_LVL_TOP : BBR_LVL_MID), boost_level_out)
    end
    // random supply around the low threshold, hysteresis modelled here
    repeat (40) begin
      v = BBR_TH1 - 10'h30 + 10'($urandom % 112);
      sensed_supply_level_in <= v;
      if (v < BBR_TH1) bon = 1'h1;
      else if (v > BBR_TH1 + BBR_HYS1) bon = 1'h0;
      cyc(3);
      `BBR_CHK("boost switch", bon, boost_on_out)
    end
    sensed_supply_level_in <= 10'h100;
    cyc(3);
    bus(1'h0, BBR_OFS_STATUS, 32'h40);
    bus(1'h0, BBR_OFS_STATUS, 32'h40);
    // each fault sets its flag and the interrupt, and nothing else moves
    bus(1'h1, BBR_OFS_MASK, 32'h3f);
    for (int b = 0; b < 5; b++) begin
      flt <= 5'(1 << b);
      cyc(2);
      flt <= 5'h0;
      cyc(2);
      `BBR_CHK("irq set", 1'h1, irq_out)
      `BBR_CHK("mode kept", 3'h7, {cascade_en_out, buck_pwm_mode_out, boost_on_out})
      bus(1'h0, BBR_OFS_STATUS, 32'h40 | 32'((b < 2) ? (1 << b) : (8 << (b - 2))));
      cyc(4);
      `BBR_CHK("irq clear", 1'h0, irq_out)
    end
    sensed_supply_level_in <= 10'h3ff;
    cyc(3);
    bus(1'h0, BBR_OFS_STATUS, 32'h40);
    bus(1'h0, BBR_OFS_STATUS, 32'h0);
    // off modes, then restart with a fresh ramp
    foreach (offm[j]) begin
      sensed_supply_level_in <= 10'h100;
      mode_to(offm[j]);
      `BBR_CHK("off", 3'h0, {cascade_en_out, boost_on_out, |buck_duty_out})
      sensed_supply_level_in <= 10'h3ff;
      mode_to(BBR_MODE_RESTART);
      `BBR_CHK("ramp", 2'h3, {cascade_en_out, soft_start_busy_out})
      settle();
    end
    // stop mode: pfm, automatic and manual pwm
    mode_to(BBR_MODE_NORMAL);
    mode_to(BBR_MODE_STOP);
    `BBR_CHK("stop pfm", 1'h0, buck_pwm_mode_out)
    load_above_pfm_limit_in <= 1'h1;
    cyc(3);
    `BBR_CHK("auto pwm", 1'h1, buck_pwm_mode_out)
    load_above_pfm_limit_in <= 1'h0;
    mode_to(BBR_MODE_NORMAL);
    mode_to(BBR_MODE_STOP);
    bus(1'h1, BBR_OFS_CTRL, 32'h10);
    wake_level_in <= 1'h1;
    cyc(3);
    `BBR_CHK("wake pwm", 1'h1, buck_pwm_mode_out)
    wake_level_in <= 1'h0;
    cyc(3);
    `BBR_CHK("wake pfm", 1'h0, buck_pwm_mode_out)
    report_and_stop();
  end
endmodule : buck_boost_regulator_control_bench
bind bbr_ctrl bbr_ctrl_checker i_bbr_ctrl_checker (.clk_sys_in, .reset_in, .sbc_mode_in, .sensed_supply_level_in,
  .main_regulated_output_in, .load_above_pfm_limit_in, .wake_level_in, .cascade_en_out, .buck_pwm_mode_out,
  .buck_duty_out, .soft_start_busy_out, .boost_on_out, .boost_level_out);
`default_nettype wire
